// *** logic/mss_defines.svh ***
// Constants of the multi-step speed selector: register offsets, field positions,
// reset values, function codes and timing counts.
// Assumes a 250 MHz sys_clk and 32-bit APB with byte addresses.
//
// What this block does
// [R1] Up to 17 preset references, the jog reference among them, are chosen by five input terminals.
// [R2] The first preset is active when no step input is on, and its unit comes from the display unit setting.
// [R3] The step bit 0 input (code 3) alone selects the second preset.
// [R4] The step bit 1 input (code 4) alone selects the third preset.
// [R5] Both step bit 0 and step bit 1 inputs together select the fourth preset.
// [R6] In local mode, or remote mode with keypad source (0), step 1 uses the first preset.
// [R7] In remote mode with analog source (1), step 1 uses the first analog input.
// [R8] With the second analog input set to auxiliary frequency (2), step 2 uses that input.
// [R9] Choosing local mode from the keypad lights the local/remote lamp.
// [R10] An accepted run command lights the run lamp steadily while the motor is driven.
// [R11] After a stop the run lamp flashes until the motor has stopped, then goes out.
// [R12] In 3-wire control a momentary closure of the first terminal starts the drive.
// [R13] A jog selection wins over every multi-step selection 1 to 16.
// [R14] Terminal inputs are synchronised and debounced before they are decoded.
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH

`define MSS_ADDR_CTRL 12'h000
`define MSS_ADDR_FUNC 12'h004
`define MSS_ADDR_STATUS 12'h008
`define MSS_ADDR_ACTIVE 12'h00C
`define MSS_PRESET_WORD 10'h010
`define MSS_NUM_PRESETS 17
`define MSS_JOG_INDEX 5'h10

`define MSS_CTRL_RESET 13'h0000
`define MSS_FUNC_RESET 30'h040C0000
`define MSS_PRESET_RESET 16'h0000
`define MSS_JOG_RESET 16'h0258

`define MSS_SRC_KEYPAD 4'h0
`define MSS_SRC_ANALOG 4'h1
`define MSS_A2_AUX 4'h2

`define MSS_FUNC_STEP0 6'h03
`define MSS_FUNC_STEP1 6'h04
`define MSS_FUNC_STEP2 6'h05
`define MSS_FUNC_STEP3 6'h20
`define MSS_FUNC_JOG 6'h06

`define MSS_STAT_LOCAL 5
`define MSS_STAT_RUN 6
`define MSS_STAT_STOPPING 7
`define MSS_STAT_LAMP 8
`define MSS_STAT_JOG 9

`define MSS_CLK_MHZ 250
`define MSS_DEBOUNCE_MS 10
`define MSS_FLASH_HALF_MS 250
`define MSS_DEBOUNCE_CYCLES (`MSS_DEBOUNCE_MS * `MSS_CLK_MHZ * 1000)
`define MSS_FLASH_CYCLES (`MSS_FLASH_HALF_MS * `MSS_CLK_MHZ * 1000)

`endif

// *** logic/mss_pkg.sv ***
// Types shared by the multi-step speed selector modules.
// Assumes nothing of its surroundings.
package mss_pkg;
  typedef enum logic [1:0] {MSS_IDLE, MSS_RUN, MSS_STOPPING} mss_state_t;
  typedef logic [5:0] mss_func_t;
  typedef struct packed
  {
    logic three_wire;
    logic [3:0] unit;
    logic [3:0] a2_func;
    logic [3:0] src;
  } mss_ctrl_t;
endpackage

// *** logic/mss_sel_if.sv ***
// Carries terminal levels and their functions to the step decoder, and the index back.
// Assumes both ends sit in the same sys_clk domain.
interface mss_sel_if;
  logic [4:0] terms;
  mss_pkg::mss_func_t [4:0] funcs;
  logic [4:0] step_index;
  logic jog;
  modport decoder(input terms, input funcs, output step_index, output jog);
  modport core(output terms, output funcs, input step_index, input jog);
endinterface

// *** logic/mss_debounce.sv ***
// Synchroniser and debouncer for the contact inputs.
// Assumes raw contacts may bounce; a level must hold DEBOUNCE_CYCLES to pass.
`include "mss_defines.svh"
module mss_debounce #(
  parameter int N = 6,
  parameter int DEBOUNCE_CYCLES = `MSS_DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Contacts.
  input wire logic [N-1:0] raw,
  output logic [N-1:0] stable
);
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DEBOUNCE_CYCLES - 1);

  if (DEBOUNCE_CYCLES < 1 || N < 1)
  begin
    $error("mss_debounce needs at least one input and one cycle");
  end

  typedef struct packed
  {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] stable;
    logic [N-1:0][CW-1:0] cnt;
  } mss_deb_state_t;

  mss_deb_state_t st;
  mss_deb_state_t next_st;

  // [R14] Sync and debounce.
  always_comb
  begin
    next_st = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    for (int i = 0; i < N; i++)
    begin
      if (st.sync2[i] == st.stable[i])
        next_st.cnt[i] = '0;
      else if (st.cnt[i] == LAST)
      begin
        next_st.cnt[i] = '0;
        next_st.stable[i] = st.sync2[i];
      end
      else
        next_st.cnt[i] = st.cnt[i] + 1'b1;
    end
    if (!reset_n)
      next_st = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
  end

  assign stable = st.stable;
endmodule

// *** logic/mss_step_decode.sv ***
// Decodes the step-select and jog functions of the terminals into a reference index.
// Assumes debounced terminal levels; purely combinational.
`include "mss_defines.svh"
module mss_step_decode (
  // Selection carrier.
  mss_sel_if.decoder sel
);
  function automatic logic func_on(input logic [4:0] terms, input mss_pkg::mss_func_t [4:0] funcs,
                                   input mss_pkg::mss_func_t code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      if (terms[i] && funcs[i] == code)
        hit = 1'b1;
    end
    return hit;
  endfunction

  logic [3:0] bits;

  // [R1] Four step bits form the index.
  always_comb
  begin
    bits[0] = func_on(sel.terms, sel.funcs, `MSS_FUNC_STEP0);
    bits[1] = func_on(sel.terms, sel.funcs, `MSS_FUNC_STEP1);
    bits[2] = func_on(sel.terms, sel.funcs, `MSS_FUNC_STEP2);
    bits[3] = func_on(sel.terms, sel.funcs, `MSS_FUNC_STEP3);
    sel.jog = func_on(sel.terms, sel.funcs, `MSS_FUNC_JOG);
    // [R13] Jog wins outright.
    if (sel.jog)
      sel.step_index = `MSS_JOG_INDEX;
    else
      sel.step_index = {1'b0, bits};
  end
endmodule

// *** logic/mss_speed_selector.sv ***
// Top of the multi-step speed selector: APB registers, run/stop sequencing,
// lamps and selection of the active frequency reference.
// Assumes contact inputs from switches, keypad keys as one-cycle pulses,
// and a motor_stopped level from the motor control.
//
// Decided for this implementation: the address map and the APB register port.
`include "mss_defines.svh"
module mss_speed_selector #(
  parameter int FREQ_W = 16,
  parameter int DEBOUNCE_CYCLES = `MSS_DEBOUNCE_CYCLES,
  parameter int FLASH_CYCLES = `MSS_FLASH_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Contact terminals, bit 0 is the first terminal.
  input wire logic [5:0] input_terminals,
  // Analog references.
  input wire logic [FREQ_W-1:0] analog_in_first,
  input wire logic [FREQ_W-1:0] analog_in_second,
  // Keypad.
  input wire logic run_key,
  input wire logic stop_key,
  input wire logic local_remote_key,
  // Motor control.
  input wire logic motor_stopped,
  output logic motor_run,
  output logic [FREQ_W-1:0] freq_reference,
  output logic [4:0] active_index,
  output logic [3:0] display_unit,
  // Lamps.
  output logic run_lamp,
  output logic local_remote_lamp
);
  localparam int NP = `MSS_NUM_PRESETS;
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);

  if (FREQ_W < 1 || FREQ_W > 32 || FLASH_CYCLES < 1)
  begin
    $error("mss_speed_selector needs FREQ_W in 1..32 and FLASH_CYCLES of at least 1");
  end

  typedef struct packed
  {
    mss_pkg::mss_state_t state;
    logic local_mode;
    mss_pkg::mss_ctrl_t ctrl;
    mss_pkg::mss_func_t [4:0] funcs;
    logic [NP-1:0][FREQ_W-1:0] presets;
    logic [31:0] rdata;
    logic [FREQ_W-1:0] freq;
    logic [4:0] idx;
    logic jog;
    logic s1_prev;
    logic [FW-1:0] flash_cnt;
    logic flash;
    logic lamp;
  } mss_top_state_t;

  mss_top_state_t st;
  mss_top_state_t next_st;
  logic [5:0] terms;

  mss_sel_if sel();

  mss_debounce #(
    .N(6),
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .raw(input_terminals),
    .stable(terms)
  );

  mss_step_decode u_decode (
    .sel(sel)
  );

  assign sel.terms = terms[5:1];
  assign sel.funcs = st.funcs;

  // Word index of a preset address, or NP when the address is not a preset.
  function automatic logic [4:0] preset_slot(input logic [11:0] addr);
    logic [9:0] word;
    word = addr[11:2];
    if (addr[1:0] == 2'b00 && word >= `MSS_PRESET_WORD && word < `MSS_PRESET_WORD + 10'(NP))
      return 5'(word - `MSS_PRESET_WORD);
    return 5'(NP);
  endfunction

  function automatic logic addr_ok(input logic [11:0] addr);
    return addr == `MSS_ADDR_CTRL || addr == `MSS_ADDR_FUNC || addr == `MSS_ADDR_STATUS ||
           addr == `MSS_ADDR_ACTIVE || preset_slot(addr) != 5'(NP);
  endfunction

  logic local_now;
  logic start_cmd;
  logic stop_cmd;
  logic [4:0] slot;
  logic [31:0] status_word;

  always_comb
  begin
    next_st = st;
    local_now = st.local_mode;
    slot = preset_slot(paddr);

    status_word = '0;
    status_word[4:0] = st.idx;
    status_word[`MSS_STAT_LOCAL] = st.local_mode;
    status_word[`MSS_STAT_RUN] = st.state == mss_pkg::MSS_RUN;
    status_word[`MSS_STAT_STOPPING] = st.state == mss_pkg::MSS_STOPPING;
    status_word[`MSS_STAT_LAMP] = st.lamp;
    status_word[`MSS_STAT_JOG] = st.jog;

    // Read data is captured in the setup cycle, so the access phase needs no wait.
    if (psel && !penable)
    begin
      next_st.rdata = '0;
      if (paddr == `MSS_ADDR_CTRL)
        next_st.rdata[12:0] = st.ctrl;
      else if (paddr == `MSS_ADDR_FUNC)
        next_st.rdata[29:0] = st.funcs;
      else if (paddr == `MSS_ADDR_STATUS)
        next_st.rdata = status_word;
      else if (paddr == `MSS_ADDR_ACTIVE)
        next_st.rdata[FREQ_W-1:0] = st.freq;
      else if (slot != 5'(NP))
        next_st.rdata[FREQ_W-1:0] = st.presets[slot];
    end

    if (psel && penable && pwrite)
    begin
      if (paddr == `MSS_ADDR_CTRL)
        next_st.ctrl = pwdata[12:0];
      else if (paddr == `MSS_ADDR_FUNC)
        next_st.funcs = pwdata[29:0];
      else if (slot != 5'(NP))
        next_st.presets[slot] = pwdata[FREQ_W-1:0];
    end

    // [R9] Keypad toggles local mode while idle.
    if (local_remote_key && st.state == mss_pkg::MSS_IDLE)
      next_st.local_mode = !st.local_mode;

    next_st.s1_prev = terms[0];
    if (local_now)
    begin
      start_cmd = run_key;
      stop_cmd = stop_key;
    end
    else if (st.ctrl.three_wire)
    begin
      // [R12] Start on closure edge.
      start_cmd = terms[0] && !st.s1_prev;
      stop_cmd = stop_key || !terms[1];
    end
    else
    begin
      start_cmd = terms[0];
      stop_cmd = stop_key || !terms[0];
    end

    unique case (st.state)
      mss_pkg::MSS_IDLE:
      begin
        if (start_cmd && !stop_cmd)
          next_st.state = mss_pkg::MSS_RUN;
      end
      mss_pkg::MSS_RUN:
      begin
        if (stop_cmd)
          next_st.state = mss_pkg::MSS_STOPPING;
      end
      mss_pkg::MSS_STOPPING:
      begin
        if (start_cmd && !stop_cmd)
          next_st.state = mss_pkg::MSS_RUN;
        else if (motor_stopped)
          next_st.state = mss_pkg::MSS_IDLE;
      end
    endcase

    // [R11] Flash while stopping.
    // Counting starts one cycle after entry, so the lamp is lit for a full half period first.
    if (st.state == mss_pkg::MSS_STOPPING && next_st.state == mss_pkg::MSS_STOPPING)
    begin
      if (st.flash_cnt == FLASH_LAST)
      begin
        next_st.flash_cnt = '0;
        next_st.flash = !st.flash;
      end
      else
        next_st.flash_cnt = st.flash_cnt + 1'b1;
    end
    else
    begin
      next_st.flash_cnt = '0;
      next_st.flash = 1'b1;
    end
    // [R10] Steady while running.
    next_st.lamp = next_st.state == mss_pkg::MSS_RUN ||
                   (next_st.state == mss_pkg::MSS_STOPPING && next_st.flash);

    next_st.idx = sel.step_index;
    next_st.jog = sel.jog;
    // [R3] [R4] [R5] Index picks preset.
    next_st.freq = st.presets[sel.step_index];
    // [R2] [R6] [R7] Step 1 source.
    if (sel.step_index == 5'h00 && !st.local_mode && st.ctrl.src == `MSS_SRC_ANALOG)
      next_st.freq = analog_in_first;
    // [R8] Step 2 auxiliary input.
    if (sel.step_index == 5'h01 && st.ctrl.a2_func == `MSS_A2_AUX)
      next_st.freq = analog_in_second;

    if (!reset_n)
    begin
      next_st = '0;
      next_st.state = mss_pkg::MSS_IDLE;
      next_st.ctrl = `MSS_CTRL_RESET;
      next_st.funcs = `MSS_FUNC_RESET;
      for (int i = 0; i < NP; i++)
        next_st.presets[i] = FREQ_W'(`MSS_PRESET_RESET);
      next_st.presets[NP-1] = FREQ_W'(`MSS_JOG_RESET);
      next_st.flash = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = st.rdata;
  assign motor_run = st.state == mss_pkg::MSS_RUN;
  assign freq_reference = st.freq;
  assign active_index = st.idx;
  assign display_unit = st.ctrl.unit;
  assign run_lamp = st.lamp;
  assign local_remote_lamp = st.local_mode;
endmodule

// *** tb/mss_chk.sv ***
// Concurrent checks on the speed selector top ports.
// Assumes one sys_clk domain and a synchronous active-low reset.
module mss_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus and keys.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic run_key,
  input wire logic stop_key,
  input wire logic local_remote_key,
  input wire logic motor_stopped,
  // Watched outputs.
  input wire logic motor_run,
  input wire logic [4:0] active_index,
  input wire logic [3:0] display_unit,
  input wire logic run_lamp,
  input wire logic local_remote_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  property p_run_lamp;
    motor_run |-> run_lamp;
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("run lamp dark while running");
  property p_run_key;
    local_remote_lamp && run_key && !stop_key |=> motor_run;
  endproperty
  a_run_key: assert property (p_run_key) else $error("local run key ignored");
  property p_stop_key;
    stop_key |=> !motor_run;
  endproperty
  a_stop_key: assert property (p_stop_key) else $error("stop key ignored");
  property p_stop_entry;
    $fell(motor_run) |-> run_lamp;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("lamp not lit at stop entry");
  property p_stop_end;
    !motor_run && motor_stopped |=> !run_lamp || motor_run;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("lamp lit after standstill");
  property p_local_hold;
    motor_run || !local_remote_key |=> $stable(local_remote_lamp);
  endproperty
  a_local_hold: assert property (p_local_hold) else $error("local lamp changed wrongly");
  property p_unit;
    psel && penable && pwrite && paddr == 12'h000 |=> display_unit == $past(pwdata[11:8]);
  endproperty
  a_unit: assert property (p_unit) else $error("display unit not taken");
  property p_idx_range;
    active_index <= 5'h10;
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("index out of range");
  c_run: cover property ($rose(motor_run));
  c_stop: cover property ($fell(motor_run));
  c_jog: cover property (active_index == 5'h10);
endmodule

bind mss_speed_selector mss_chk chk_i (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .run_key(run_key), .stop_key(stop_key),
  .local_remote_key(local_remote_key), .motor_stopped(motor_stopped), .motor_run(motor_run),
  .active_index(active_index), .display_unit(display_unit), .run_lamp(run_lamp),
  .local_remote_lamp(local_remote_lamp));

// *** tb/mss_contacts.sv ***
// Contact switch model for the terminal inputs.
// Assumes the bench sets wanted levels; each change bounces four cycles first.
module mss_contacts (
  // Clock.
  input wire logic sys_clk,
  // Wanted and actual contact levels.
  input wire logic [5:0] want,
  output logic [5:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] last = 6'h00;
  logic [5:0] prev = 6'h00;
  logic [2:0] cnt = 3'h0;
  always @(posedge sys_clk)
  begin
    if (want != last)
    begin
      prev <= level;
      last <= want;
      cnt <= 3'h4;
    end
    else if (cnt != 3'h0)
    begin
      level <= cnt[0] ? last : prev;
      cnt <= cnt - 3'h1;
    end
    else
      level <= want;
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the multi-step speed selector.
// Assumes short debounce and flash counts and a contact model on the terminals.
`include "mss_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, serr, run_key = 0, stop_key = 0, lr_key = 0, motor_stopped = 1;
  logic [5:0] want = 6'h00, term;
  logic [15:0] a1 = 16'h1234, a2 = 16'h0ABC, freq;
  logic [4:0] idx;
  logic [3:0] unit;
  logic motor_run, run_lamp, lr_lamp;
  logic [15:0] pv [4] = '{16'h01F4, 16'h07D0, 16'h0FA0, 16'h1388};
  int err_total = 0, n_compared = 0;
  mss_contacts sw (.sys_clk(sys_clk), .want(want), .level(term));
  mss_speed_selector #(.FREQ_W(16), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8)) uut (.sys_clk(sys_clk),
    .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_terminals(term), .analog_in_first(a1),
    .analog_in_second(a2), .run_key(run_key), .stop_key(stop_key), .local_remote_key(lr_key),
    .motor_stopped(motor_stopped), .motor_run(motor_run), .freq_reference(freq), .active_index(idx),
    .display_unit(unit), .run_lamp(run_lamp), .local_remote_lamp(lr_lamp));
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    // One idle cycle keeps the next setup from reassigning psel in this time step.
    @(posedge sys_clk);
  endtask
  task settle();
    repeat (20) @(posedge sys_clk);
  endtask
  // Pulses one keypad key for a cycle: 0 run, 1 stop, otherwise local/remote.
  task key(input int k);
    if (k == 0)
      run_key <= 1;
    else if (k == 1)
      stop_key <= 1;
    else
      lr_key <= 1;
    @(posedge sys_clk);
    run_key <= 0;
    stop_key <= 0;
    lr_key <= 0;
    @(posedge sys_clk);
  endtask
  task t_reset();
    apb(0, `MSS_ADDR_CTRL, 0);
    chk("ctrl", q, 0);
    apb(0, `MSS_ADDR_FUNC, 0);
    chk("func", q, 32'h040C0000);
    apb(0, 12'h080, 0);
    chk("jog preset", q, 32'h00000258);
    apb(0, `MSS_ADDR_STATUS, 0);
    chk("reset status", q, 32'h00000000);
    apb(0, 12'h100, 0);
    chk("unmapped err", serr, 1);
    chk("index", idx, 0);
  endtask
  task t_steps();
    for (int i = 0; i < 4; i++)
      apb(1, 12'h040 + 12'(4 * i), 32'(pv[i]));
    for (int i = 1; i < 5; i++)
    begin
      want <= {i[1], i[0], 4'h0};
      repeat (4) @(posedge sys_clk);
      chk("bouncing index", idx, 5'(i - 1));
      settle();
      chk("step index", idx, 5'(i & 3));
      chk("step freq", freq, pv[i & 3]);
    end
  endtask
  task t_jog();
    // Terminal 2 step bit 2, terminal 3 step bit 3, terminal 4 jog, terminals 5 and 6 as after reset.
    apb(1, `MSS_ADDR_FUNC, 32'h040C6805);
    apb(1, 12'h07C, 32'h00000F0F);
    want <= 6'h36;
    settle();
    chk("top step index", idx, 5'h0F);
    chk("top step freq", freq, 16'h0F0F);
    want <= 6'h3E;
    settle();
    chk("jog index", idx, 5'h10);
    chk("jog freq", freq, 16'h0258);
    apb(0, `MSS_ADDR_ACTIVE, 0);
    chk("jog active", q, 32'h00000258);
    apb(0, `MSS_ADDR_STATUS, 0);
    chk("jog status", q, 32'h00000210);
    want <= 6'h00;
    settle();
  endtask
  task t_analog();
    apb(1, `MSS_ADDR_CTRL, 32'h00000301);
    settle();
    chk("unit", unit, 4'h3);
    chk("remote analog", freq, a1);
    key(2);
    settle();
    chk("local lamp", lr_lamp, 1);
    chk("local preset", freq, pv[0]);
    apb(1, `MSS_ADDR_CTRL, 32'h00000021);
    want <= 6'h10;
    settle();
    chk("aux freq", freq, a2);
    want <= 6'h00;
    settle();
  endtask
  task t_run_stop();
    int on, tg;
    logic pl;
    on = 0;
    tg = 0;
    key(0);
    motor_stopped <= 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      on += (run_lamp === 1'b1);
    end
    chk("run", motor_run, 1);
    chk("steady lamp", on, 20);
    key(1);
    chk("stopping", motor_run, 0);
    pl = run_lamp;
    repeat (40)
    begin
      @(posedge sys_clk);
      tg += (run_lamp !== pl);
      pl = run_lamp;
    end
    chk("flashing", tg >= 4, 1);
    motor_stopped <= 1;
    repeat (3) @(posedge sys_clk);
    chk("lamp out", run_lamp, 0);
  endtask
  task t_three_wire();
    key(2);
    apb(1, `MSS_ADDR_CTRL, 32'h00001000);
    want <= 6'h02;
    settle();
    want <= 6'h03;
    settle();
    want <= 6'h02;
    settle();
    chk("pulse start", motor_run, 1);
    want <= 6'h00;
    settle();
    chk("wire stop", motor_run, 0);
    apb(1, `MSS_ADDR_CTRL, 32'h00000000);
    want <= 6'h01;
    settle();
    chk("two wire run", motor_run, 1);
    want <= 6'h00;
    settle();
    chk("two wire stop", motor_run, 0);
  endtask
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
    t_reset();
    t_steps();
    t_jog();
    t_analog();
    t_run_stop();
    t_three_wire();
    summarize();
  end
endmodule
